// *** src/icsr_params.svh ***
/*
 * Constants for the interface configuration status register block:
 * port addresses, index, bit positions and reset values.
 * Assumes inclusion by the testbench and the design module only.
 */
`ifndef ICSR_PARAMS_SVH
`define ICSR_PARAMS_SVH

// ==========================================================
// Addresses
`define ICSR_PORT_MONO 16'h03b5
`define ICSR_PORT_COLOR 16'h03d5
`define ICSR_INDEX 8'h27

// ==========================================================
// Bit positions
`define ICSR_BIT_SLOWCLK 6
`define ICSR_BIT_SEQ 5
`define ICSR_BIT_INHIBIT 4
`define ICSR_BIT_DRAM 3
`define ICSR_BIT_LBT_UP 2
`define ICSR_BIT_LBT_LO 1
`define ICSR_BIT_ISA 0

// ==========================================================
// Reset values
`define ICSR_RST_STRAPS 3'h0
`define ICSR_RST_SYNC 4'h0
`define ICSR_RST_RDATA 8'h00
`define ICSR_RST_WARM 2'h0

// ==========================================================
// Timing counts
`define ICSR_WARM_DONE 2'h3

`endif

// *** src/icsr_pkg.sv ***
/*
 * Types for the interface configuration status register block.
 * Assumes the params header sits beside it.
 */
package icsr_pkg;

    // ======================================================
    // Host bus type, one-hot
    typedef enum logic [3:0] {
        ICSR_BUS_ISA = 4'h1,
        ICSR_BUS_LOCAL_A = 4'h2,
        ICSR_BUS_LOCAL_B = 4'h4,
        ICSR_BUS_LOCAL_C = 4'h8
    } icsr_bus_t;

    // Live pin levels after synchronising
    typedef struct packed {
        logic slow_clock;
        logic inhibit;
        logic dram_strobe;
        logic seq_active;
    } icsr_live_t;

    // Latched bus straps
    typedef struct packed {
        logic upper;
        logic lower;
        logic isa;
    } icsr_strap_t;

endpackage

// *** src/icsr_status_reg.sv ***
/*
 * Interface configuration status register: an indexed read-only port
 * reporting latched straps and live pin levels.
 * Assumes an I/O host cycle in the ref_clk domain with one-cycle strobes;
 * pins are asynchronous and are synchronised here.
 */
`timescale 1ns/1ns
`include "icsr_params.svh"
module icsr_status_reg
    import icsr_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Host I/O port
    input wire logic [15:0] io_addr,
    input wire logic io_rd_stb,
    input wire logic io_wr_stb,
    input wire logic [7:0] io_wdata,
    input wire logic color_mode,
    input wire logic hw_suspend,
    output logic [7:0] io_rdata,
    output logic io_rd_ack,
    // Pins
    input wire logic slow_clock_input,
    input wire logic power_down_inhibit_pin,
    input wire logic dram_strobe_select_pin,
    input wire logic bus_type_strap_upper,
    input wire logic bus_type_strap_lower,
    input wire logic isa_select_strap,
    input wire logic panel_seq_active,
    // Decoded configuration
    output icsr_bus_t host_bus_type,
    output logic pd_timers_enable,
    output logic dram_dual_cas
);

    // ======================================================
    // Synchronisers
    icsr_live_t live_m_q;
    icsr_live_t live_q;
    icsr_strap_t strap_m_q;
    icsr_strap_t strap_s_q;
    icsr_strap_t strap_q;
    logic latched_q;
    logic [1:0] warm_q;
    logic [7:0] index_q;
    logic [7:0] rdata_q;
    logic ack_q;
    logic [7:0] stat_d;

    function automatic logic port_hit(input logic [15:0] a,
                                      input logic col);
        port_hit = (a == (col ? `ICSR_PORT_COLOR : `ICSR_PORT_MONO));
    endfunction

    // Two-stage sync of live pins
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            live_m_q <= icsr_live_t'(`ICSR_RST_SYNC);
            live_q <= icsr_live_t'(`ICSR_RST_SYNC);
        end else begin
            live_m_q <= {slow_clock_input, power_down_inhibit_pin,
                         dram_strobe_select_pin, panel_seq_active};
            live_q <= live_m_q;
        end
    end

    // Strap sync, captured once the second stage holds a pin level
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            strap_m_q <= icsr_strap_t'(`ICSR_RST_STRAPS);
            strap_s_q <= icsr_strap_t'(`ICSR_RST_STRAPS);
            strap_q <= icsr_strap_t'(`ICSR_RST_STRAPS);
            warm_q <= `ICSR_RST_WARM;
            latched_q <= 1'b0;
        end else begin
            strap_m_q <= {bus_type_strap_upper, bus_type_strap_lower,
                          isa_select_strap};
            strap_s_q <= strap_m_q;
            warm_q <= {warm_q[0], 1'b1}; // Skip reset-filled stages
            if (warm_q == `ICSR_WARM_DONE && !latched_q) begin
                strap_q <= strap_s_q;
                latched_q <= 1'b1;
            end
        end
    end

    // ======================================================
    // Status word
    always_comb begin
        stat_d = 8'h00;
        stat_d[`ICSR_BIT_SLOWCLK] = live_q.slow_clock;
        stat_d[`ICSR_BIT_SEQ] = live_q.seq_active;
        stat_d[`ICSR_BIT_INHIBIT] = live_q.inhibit;
        stat_d[`ICSR_BIT_DRAM] = live_q.dram_strobe;
        stat_d[`ICSR_BIT_LBT_UP] = strap_q.upper;
        stat_d[`ICSR_BIT_LBT_LO] = strap_q.lower;
        stat_d[`ICSR_BIT_ISA] = strap_q.isa;
    end

    // Bus type decode
    always_comb begin
        if (strap_q.isa) begin
            host_bus_type = ICSR_BUS_ISA;
        end else begin
            case ({strap_q.upper, strap_q.lower})
                2'h1: host_bus_type = ICSR_BUS_LOCAL_A;
                2'h2: host_bus_type = ICSR_BUS_LOCAL_B;
                2'h3: host_bus_type = ICSR_BUS_LOCAL_C;
                default: host_bus_type = ICSR_BUS_ISA;
            endcase
        end
    end

    // Timer enable and DRAM mode outputs
    assign pd_timers_enable = ~live_q.inhibit;
    assign dram_dual_cas = live_q.dram_strobe;

    // ======================================================
    // Index register: write at port minus one
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            index_q <= 8'h00;
        end else if (io_wr_stb && !hw_suspend
                     && port_hit(io_addr + 16'h0001, color_mode)) begin
            index_q <= io_wdata;
        end
    end

    // Read data; writes to data port ignored
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rdata_q <= `ICSR_RST_RDATA;
            ack_q <= 1'b0;
        end else begin
            ack_q <= 1'b0;
            if (io_rd_stb && !hw_suspend
                && port_hit(io_addr, color_mode)
                && index_q == `ICSR_INDEX) begin
                rdata_q <= stat_d;
                ack_q <= 1'b1;
            end
        end
    end

    assign io_rdata = rdata_q;
    assign io_rd_ack = ack_q;

    // ======================================================
    // Checks
    reserved_zero_a: assert property (
        @(posedge ref_clk) disable iff (rst) io_rd_ack |-> !io_rdata[7])
        else $error("reserved bit set");
    suspend_lock_a: assert property (
        @(posedge ref_clk) disable iff (rst) hw_suspend |=> !io_rd_ack)
        else $error("read acked in suspend");
    read_ack_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        (io_rd_stb && !hw_suspend && port_hit(io_addr, color_mode)
         && index_q == `ICSR_INDEX) |=> io_rd_ack)
        else $error("read not acked");
    slow_clk_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        !$past(rst, 2) && !$past(rst, 3) && io_rd_ack
        |-> io_rdata[6] == $past(slow_clock_input, 3))
        else $error("slow clock bit wrong");
    seq_bit_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        !$past(rst, 2) && !$past(rst, 3) && io_rd_ack
        |-> io_rdata[5] == $past(panel_seq_active, 3))
        else $error("sequence bit wrong");
    timer_gate_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        !$past(rst) && !$past(rst, 2) && $past(power_down_inhibit_pin, 2)
        |-> !pd_timers_enable)
        else $error("timers not disabled");
    dram_bit_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        io_rd_ack |-> io_rdata[3] == $past(dram_dual_cas))
        else $error("dram bit wrong");
    isa_decode_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        strap_q.isa |-> host_bus_type == ICSR_BUS_ISA)
        else $error("isa decode wrong");
    strap_hold_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        latched_q && $past(latched_q) |-> $stable(strap_q))
        else $error("straps changed");
    strap_ready_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        !$past(rst) && !$past(rst, 2) && !$past(rst, 3) |-> latched_q)
        else $error("straps not latched");
    index_refuse_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        (io_rd_stb && index_q != `ICSR_INDEX) |=> !io_rd_ack)
        else $error("read acked at other index");
    rdata_hold_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        !$past(rst) && $changed(io_rdata) |-> io_rd_ack)
        else $error("read data moved without ack");
    write_silent_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        (io_wr_stb && !io_rd_stb) |=> !io_rd_ack)
        else $error("write acked");
    suspend_index_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        hw_suspend |=> $stable(index_q))
        else $error("index moved in suspend");
    timer_run_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        !$past(rst) && !$past(rst, 2) && !$past(power_down_inhibit_pin, 2)
        |-> pd_timers_enable)
        else $error("timers disabled without inhibit");
    local_one_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        (!strap_q.isa && !strap_q.upper && strap_q.lower)
        |-> host_bus_type == ICSR_BUS_LOCAL_A)
        else $error("local bus one decode wrong");
    local_two_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        (!strap_q.isa && strap_q.upper && !strap_q.lower)
        |-> host_bus_type == ICSR_BUS_LOCAL_B)
        else $error("local bus two decode wrong");
    local_three_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        (!strap_q.isa && strap_q.upper && strap_q.lower)
        |-> host_bus_type == ICSR_BUS_LOCAL_C)
        else $error("local bus three decode wrong");

endmodule // icsr_status_reg

// *** test/icsr_host_model.sv ***
/* Host model: one-cycle I/O read and write strobes.
   Assumes the bench calls its tasks by hierarchical name. */
`timescale 1ns/1ns
module icsr_host_model (
    // Clock
    input wire logic ref_clk,
    // Request side
    output logic [15:0] io_addr,
    output logic io_rd_stb,
    output logic io_wr_stb,
    output logic [7:0] io_wdata,
    // Answer side
    input wire logic [7:0] io_rdata,
    input wire logic io_rd_ack
);
    // ==========
    // Idle bus at time zero
    initial begin
        io_addr = 16'h0000;
        io_rd_stb = 1'b0;
        io_wr_stb = 1'b0;
        io_wdata = 8'h00;
    end

    // Write; bus scrambled on release
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        io_addr <= a;
        io_wdata <= d;
        io_wr_stb <= 1'b1;
        @(posedge ref_clk);
        io_wr_stb <= 1'b0;
        io_addr <= ~a;
        io_wdata <= ~d;
    endtask

    // Read; answer taken at the edge after the taking edge
    task automatic rd(input logic [15:0] a, output logic k,
                      output logic [7:0] d);
        @(posedge ref_clk);
        io_addr <= a;
        io_rd_stb <= 1'b1;
        @(posedge ref_clk);
        io_rd_stb <= 1'b0;
        io_addr <= ~a;
        @(posedge ref_clk);
        k = io_rd_ack;
        d = io_rdata;
    endtask
endmodule // icsr_host_model

// *** test/strap_config_status_reg_tb.sv ***
/* Bench for the status register: straps, live pins, refusals.
   Assumes the design and host model are compiled first. */
`timescale 1ns/1ns
`include "icsr_params.svh"
module strap_config_status_reg_tb
    import icsr_pkg::*;
;
    // ==========
    // Signals
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic color_mode = 1'b1;
    logic hw_suspend = 1'b0;
    logic [3:0] live = 4'h0; // Slow clock, sequence, inhibit, dram
    logic [2:0] straps = 3'h0; // Upper, lower, isa
    logic [15:0] io_addr;
    logic [7:0] io_wdata, io_rdata, rdata;
    logic io_rd_stb, io_wr_stb, io_rd_ack, ack, pd_en, dual_cas;
    icsr_bus_t bus_type;
    int n_fail = 0;
    int n_checks = 0;
    logic [2:0] tbl [6] = '{3'h1, 3'h7, 3'h2, 3'h4, 3'h6, 3'h0};
    icsr_bus_t bus [6] = '{ICSR_BUS_ISA, ICSR_BUS_ISA, ICSR_BUS_LOCAL_A,
        ICSR_BUS_LOCAL_B, ICSR_BUS_LOCAL_C, ICSR_BUS_ISA};

    always #50 ref_clk = ~ref_clk;

    icsr_status_reg dut (.ref_clk(ref_clk), .rst(rst), .io_addr(io_addr),
        .io_rd_stb(io_rd_stb), .io_wr_stb(io_wr_stb), .io_wdata(io_wdata),
        .color_mode(color_mode), .hw_suspend(hw_suspend),
        .io_rdata(io_rdata), .io_rd_ack(io_rd_ack),
        .slow_clock_input(live[3]), .panel_seq_active(live[2]),
        .power_down_inhibit_pin(live[1]), .dram_strobe_select_pin(live[0]),
        .bus_type_strap_upper(straps[2]), .bus_type_strap_lower(straps[1]),
        .isa_select_strap(straps[0]), .host_bus_type(bus_type),
        .pd_timers_enable(pd_en), .dram_dual_cas(dual_cas));
    icsr_host_model host (.ref_clk(ref_clk), .io_addr(io_addr),
        .io_rd_stb(io_rd_stb), .io_wr_stb(io_wr_stb), .io_wdata(io_wdata),
        .io_rdata(io_rdata), .io_rd_ack(io_rd_ack));

    // ==========
    // Helpers
    task automatic check(input string what, input logic [7:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Expected status from pins
    function automatic logic [7:0] st();
        return {1'b0, live, straps};
    endfunction

    // Read a port, compare ack, and data only when an ack is expected
    task automatic rd(input logic [15:0] a, input logic ok,
                      input logic [7:0] exp);
        host.rd(a, ack, rdata);
        check("read ack", {7'h00, ack}, {7'h00, ok});
        if (ok)
            check("status", rdata, exp);
    endtask

    // Reset with given straps, then select the register
    task automatic boot(input logic [2:0] s);
        @(posedge ref_clk);
        straps <= s;
        rst <= 1'b1;
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (4) @(posedge ref_clk);
        host.wr(`ICSR_PORT_COLOR - 16'h1, `ICSR_INDEX);
    endtask

    // ==========
    // Tests
    initial begin
        for (int i = 0; i < 6; i++) begin
            boot(tbl[i]);
            rd(`ICSR_PORT_COLOR, 1'b1, st());
            check("bus", {4'h0, bus_type}, {4'h0, bus[i]});
        end
        $display("test straps done");
        for (int i = 0; i < 16; i++) begin
            @(posedge ref_clk);
            live <= i[3:0];
            repeat (4) @(posedge ref_clk);
            rd(`ICSR_PORT_COLOR, 1'b1, st());
            check("timers", {7'h00, pd_en}, {7'h00, !live[1]});
            check("cas", {7'h00, dual_cas}, {7'h00, live[0]});
        end
        $display("test live pins done");
        host.wr(`ICSR_PORT_COLOR, 8'hff);
        rd(`ICSR_PORT_COLOR, 1'b1, st());
        rd(`ICSR_PORT_MONO, 1'b0, 8'h00);
        @(posedge ref_clk);
        color_mode <= 1'b0;
        host.wr(`ICSR_PORT_MONO - 16'h1, `ICSR_INDEX);
        rd(`ICSR_PORT_MONO, 1'b1, st());
        rd(`ICSR_PORT_COLOR, 1'b0, 8'h00);
        host.wr(`ICSR_PORT_MONO - 16'h1, 8'h25);
        rd(`ICSR_PORT_MONO, 1'b0, 8'h00);
        host.wr(`ICSR_PORT_MONO - 16'h1, `ICSR_INDEX);
        @(posedge ref_clk);
        hw_suspend <= 1'b1;
        host.wr(`ICSR_PORT_MONO - 16'h1, 8'h25);
        rd(`ICSR_PORT_MONO, 1'b0, 8'h00);
        @(posedge ref_clk);
        hw_suspend <= 1'b0;
        rd(`ICSR_PORT_MONO, 1'b1, st());
        $display("test refusals done");
        conclude();
    end

    // Watchdog against a hung handshake
    initial begin
        repeat (3000) @(posedge ref_clk);
        n_fail++;
        conclude();
    end
endmodule // strap_config_status_reg_tb
